// ===== logic/abe_core.sv
// AES-128 single block encrypt unit with record DMA, event flags and interrupt
//
// Function
// - Forward AES-128 encryption only; no decryption path exists.
// - Start fetches key and input block by DMA before ciphering.
// - Done event rises only after the whole output block is written.
// - Stop trigger aborts any operation in progress.
// - Stop or error ends the operation with the abort event, not done.
// - Lowest priority on shared core; a claim abandons operation with abort.
// - DMA addresses stay inside the data RAM window.
// - No memory access once done or abort event is raised.
// - Record holds key at 0, input at 16, output at 32.
// - One block takes about 6 us from start to done.
`timescale 1ns/1ps
module abe_core #(
    parameter int unsigned RUN_CYCLES = abe_pkg::RUN_CYCLES_DEF,
    parameter logic [31:0] RAM_BASE   = abe_pkg::RAM_BASE_DEF,
    parameter logic [31:0] RAM_SIZE   = abe_pkg::RAM_SIZE_DEF
) (
    input  wire logic             ref_clk_in,    // System clock
    input  wire logic             nrst_in,       // Synchronous reset, active low
    input  wire abe_pkg::abe_bus_s bus_in,       // Register access request
    output logic [31:0]           rdata_out,     // Read data, cycle after read
    output logic                  irq_out,       // Interrupt level
    output abe_pkg::abe_dma_s     dma_out,       // DMA master request
    input  wire logic             dma_ack_in,    // DMA transfer taken
    input  wire logic [31:0]      dma_rdata_in,  // DMA read data with ack
    input  wire logic             core_claim_in, // Higher priority user claims core
    output logic                  core_req_out   // Unit holds the shared core
);
    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (RUN_CYCLES < abe_pkg::RUN_CYCLES_MIN || RUN_CYCLES > 65535) begin : g_bad_run
        $error("RUN_CYCLES outside 24..65535");
    end
    if ({1'b0, RAM_BASE} + {1'b0, RAM_SIZE} > 33'h1_0000_0000) begin : g_bad_ram
        $error("RAM window wraps the address space");
    end

    localparam logic [15:0] RUN_LAST = 16'(RUN_CYCLES - 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        abe_pkg::abe_state_e st;
        logic [127:0]        key;
        logic [127:0]        blk;
        logic [3:0]          widx;
        logic [3:0]          rnd;
        logic [15:0]         elapsed;
        logic [31:0]         ptr;
        logic [31:0]         base;
        logic                done;
        logic                abrt;
        logic [1:0]          ien;
        logic [31:0]         rdata;
        logic                irq;
        logic                core_req;
        abe_pkg::abe_dma_s   dma;
    } abe_regs_s;

    abe_regs_s r;
    abe_regs_s next_r;

    // ****************************************************************
    // Cipher arithmetic
    // ****************************************************************
    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? abe_pkg::GF_POLY : 8'h00);
    endfunction
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] m;
        p = 8'h00;
        m = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ m;
            end
            m = xt(m);
        end
        return p;
    endfunction
    // Inverse as x^254 = x^2 * x^4 * ... * x^128, then the affine map
    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [7:0] sq;
        logic [7:0] inv;
        sq  = x;
        inv = abe_pkg::RCON_FIRST;
        for (int i = 0; i < 7; i++) begin
            sq  = gf_mul(sq, sq);
            inv = gf_mul(inv, sq);
        end
        return inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]} ^ {inv[4:0], inv[7:5]}
               ^ {inv[3:0], inv[7:4]} ^ abe_pkg::SBOX_AFFINE;
    endfunction
    function automatic logic [7:0] rcon(input logic [3:0] rnd);
        logic [7:0] rc;
        rc = abe_pkg::RCON_FIRST;
        for (int i = 1; i < 10; i++) begin
            if (4'(i) < rnd) begin
                rc = xt(rc);
            end
        end
        return rc;
    endfunction
    // Byte i of a block sits at bits 8*i; column c holds bytes 4c..4c+3
    function automatic logic [127:0] next_key(input logic [127:0] k, input logic [3:0] rnd);
        logic [31:0] t;
        logic [31:0] n0;
        logic [31:0] n1;
        logic [31:0] n2;
        t  = {sbox(k[103:96]), sbox(k[127:120]), sbox(k[119:112]), sbox(k[111:104])};
        t  = t ^ {24'h00_0000, rcon(rnd)};
        n0 = k[31:0] ^ t;
        n1 = k[63:32] ^ n0;
        n2 = k[95:64] ^ n1;
        return {k[127:96] ^ n2, n2, n1, n0};
    endfunction
    function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] rk,
                                               input logic last);
        logic [127:0] t;
        logic [127:0] m;
        logic [7:0]   a0;
        logic [7:0]   a1;
        logic [7:0]   a2;
        logic [7:0]   a3;
        t = '0;
        m = '0;
        for (int c = 0; c < 4; c++) begin
            for (int q = 0; q < 4; q++) begin
                t[8*(4*c+q) +: 8] = sbox(s[8*(4*((c+q)%4)+q) +: 8]);
            end
        end
        for (int c = 0; c < 4; c++) begin
            a0 = t[32*c +: 8];
            a1 = t[32*c+8 +: 8];
            a2 = t[32*c+16 +: 8];
            a3 = t[32*c+24 +: 8];
            m[32*c +: 8]    = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
            m[32*c+8 +: 8]  = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
            m[32*c+16 +: 8] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
            m[32*c+24 +: 8] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
        end
        return (last ? t : m) ^ rk;
    endfunction
    // Whole record must lie in RAM and be word aligned
    function automatic logic in_ram(input logic [31:0] p);
        return (p[1:0] == 2'h0) && (p >= RAM_BASE)
               && ({1'b0, p} + abe_pkg::REC_BYTES <= {1'b0, RAM_BASE} + {1'b0, RAM_SIZE});
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic wr_start;
    logic wr_stop;
    logic busy;
    logic kill;

    assign wr_start = bus_in.wr && bus_in.addr == abe_pkg::OFS_START
                      && bus_in.wdata[abe_pkg::BIT_TRIG];
    assign wr_stop  = bus_in.wr && bus_in.addr == abe_pkg::OFS_STOP
                      && bus_in.wdata[abe_pkg::BIT_TRIG];
    assign busy     = r.st != abe_pkg::ST_IDLE;
    assign kill     = busy && (wr_stop || core_claim_in);

    always_comb begin
        logic [127:0] pt;
        pt     = r.blk;
        next_r = r;
        next_r.rdata = 32'h0000_0000;

        // Flags are cleared by writing zero; a set in the same cycle wins
        if (bus_in.wr && bus_in.addr == abe_pkg::OFS_DONE && !bus_in.wdata[abe_pkg::BIT_FLAG]) begin
            next_r.done = 1'b0;
        end
        if (bus_in.wr && bus_in.addr == abe_pkg::OFS_ABORT && !bus_in.wdata[abe_pkg::BIT_FLAG]) begin
            next_r.abrt = 1'b0;
        end
        if (bus_in.wr && bus_in.addr == abe_pkg::OFS_IEN_SET) begin
            next_r.ien = r.ien | bus_in.wdata[1:0];
        end
        if (bus_in.wr && bus_in.addr == abe_pkg::OFS_IEN_CLR) begin
            next_r.ien = r.ien & ~bus_in.wdata[1:0];
        end
        if (bus_in.wr && bus_in.addr == abe_pkg::OFS_PTR) begin
            next_r.ptr = bus_in.wdata;
        end
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                abe_pkg::OFS_DONE:    next_r.rdata = {31'h0000_0000, r.done};
                abe_pkg::OFS_ABORT:   next_r.rdata = {31'h0000_0000, r.abrt};
                abe_pkg::OFS_IEN_SET: next_r.rdata = {30'h0000_0000, r.ien};
                abe_pkg::OFS_IEN_CLR: next_r.rdata = {30'h0000_0000, r.ien};
                abe_pkg::OFS_PTR:     next_r.rdata = r.ptr;
                default:              next_r.rdata = 32'h0000_0000;
            endcase
        end
        if (busy) begin
            next_r.elapsed = r.elapsed + 16'h0001;
        end
        unique case (r.st)
            abe_pkg::ST_IDLE: begin
                if (wr_start) begin
                    if (in_ram(r.ptr)) begin
                        next_r.st      = abe_pkg::ST_FETCH;
                        next_r.base    = r.ptr;
                        next_r.widx    = 4'h0;
                        next_r.elapsed = 16'h0000;
                    end else begin
                        next_r.abrt = 1'b1;
                    end
                end
            end
            abe_pkg::ST_FETCH: begin
                if (dma_ack_in) begin
                    next_r.widx = r.widx + 4'h1;
                    if (r.widx < abe_pkg::KEY_WORDS) begin
                        next_r.key[32*r.widx[1:0] +: 32] = dma_rdata_in;
                    end else begin
                        pt[32*r.widx[1:0] +: 32] = dma_rdata_in;
                        next_r.blk = pt;
                    end
                    if (r.widx == abe_pkg::FETCH_LAST) begin
                        next_r.blk = pt ^ r.key;
                        next_r.rnd = abe_pkg::ROUND_FIRST;
                        next_r.st  = abe_pkg::ST_ROUND;
                    end
                end
            end
            abe_pkg::ST_ROUND: begin
                next_r.key = next_key(r.key, r.rnd);
                next_r.blk = aes_round(r.blk, next_r.key, r.rnd == abe_pkg::ROUND_LAST);
                next_r.rnd = r.rnd + 4'h1;
                if (r.rnd == abe_pkg::ROUND_LAST) begin
                    next_r.widx = 4'h0;
                    next_r.st   = abe_pkg::ST_STORE;
                end
            end
            abe_pkg::ST_STORE: begin
                if (dma_ack_in) begin
                    next_r.widx = r.widx + 4'h1;
                    if (r.widx == abe_pkg::STORE_LAST) begin
                        next_r.st = abe_pkg::ST_WAIT;
                    end
                end
            end
            // pad run time; done only after write back
            abe_pkg::ST_WAIT: begin
                if (r.elapsed >= RUN_LAST && !kill) begin
                    next_r.done = 1'b1;
                    next_r.st   = abe_pkg::ST_IDLE;
                end
            end
            default: next_r.st = abe_pkg::ST_IDLE;
        endcase
        // stop, core claim: abandon and raise abort
        if (kill) begin
            next_r.st   = abe_pkg::ST_IDLE;
            next_r.abrt = 1'b1;
        end
        // DMA request follows the state; none while idle
        next_r.dma.req   = next_r.st == abe_pkg::ST_FETCH || next_r.st == abe_pkg::ST_STORE;
        next_r.dma.we    = next_r.st == abe_pkg::ST_STORE;
        next_r.dma.addr  = next_r.base + (next_r.dma.we ? abe_pkg::REC_OUT_OFS : 32'h0000_0000)
                           + {26'h000_0000, next_r.widx, 2'h0};
        next_r.dma.wdata = next_r.blk[32*next_r.widx[1:0] +: 32];
        next_r.core_req  = next_r.st != abe_pkg::ST_IDLE;
        next_r.irq = (next_r.done && next_r.ien[abe_pkg::BIT_IE_DONE])
                     || (next_r.abrt && next_r.ien[abe_pkg::BIT_IE_ABRT]);
    end

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            r     <= '0;
            r.ien <= abe_pkg::IEN_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_out    = r.rdata;
    assign irq_out      = r.irq;
    assign dma_out      = r.dma;
    assign core_req_out = r.core_req;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    chk_fetch_then_round: assert property (
        (r.st == abe_pkg::ST_FETCH && dma_ack_in && r.widx == abe_pkg::FETCH_LAST && !kill)
        |=> (r.st == abe_pkg::ST_ROUND && !r.dma.req)
    ) else $error("cipher did not start after the last fetch");
    chk_done_after_store: assert property (
        $rose(r.done) |-> ($past(r.st) == abe_pkg::ST_WAIT && !r.dma.req && r.st == abe_pkg::ST_IDLE)
    ) else $error("done raised before write back ended");
    chk_stop_aborts: assert property (
        (wr_stop && busy) |=> (r.st == abe_pkg::ST_IDLE && r.abrt && !r.dma.req)
    ) else $error("stop did not abort the operation");
    chk_abort_not_done: assert property (
        (kill && !r.done) |=> !r.done
    ) else $error("aborted operation raised done");
    chk_claim_aborts: assert property (
        (core_claim_in && busy) |=> (r.st == abe_pkg::ST_IDLE && r.abrt && !r.core_req)
    ) else $error("core claim did not abandon the operation");
    chk_ram_window: assert property (
        r.dma.req |-> (r.dma.addr >= RAM_BASE
                       && {1'b0, r.dma.addr} + abe_pkg::WORD_BYTES <= {1'b0, RAM_BASE} + {1'b0, RAM_SIZE})
    ) else $error("DMA address outside data RAM");
    chk_quiet_after: assert property (
        ($rose(r.done) || $rose(r.abrt)) |-> (!r.dma.req [*3])
    ) else $error("memory access after an event");
    chk_out_offset: assert property (
        (r.dma.req && r.dma.we)
        |-> r.dma.addr == r.base + abe_pkg::REC_OUT_OFS + {26'h000_0000, r.widx, 2'h0}
    ) else $error("output word written at wrong offset");
    chk_ien_set: assert property (
        (bus_in.wr && bus_in.addr == abe_pkg::OFS_IEN_SET)
        |=> ((r.ien & $past(bus_in.wdata[1:0])) == $past(bus_in.wdata[1:0]))
    ) else $error("enable set did not take");
    chk_ien_clr: assert property (
        (bus_in.wr && bus_in.addr == abe_pkg::OFS_IEN_CLR)
        |=> ((r.ien & $past(bus_in.wdata[1:0])) == 2'h0)
    ) else $error("enable clear did not take");
    chk_run_time: assert property (
        $rose(r.done) |-> $past(r.elapsed) >= RUN_LAST
    ) else $error("block finished before its run time");
    chk_irq_level: assert property (
        ((r.done && r.ien[abe_pkg::BIT_IE_DONE]) || (r.abrt && r.ien[abe_pkg::BIT_IE_ABRT]))
        == r.irq
    ) else $error("interrupt level disagrees with flags");
    chk_start_ignored: assert property (
        (wr_start && busy && !kill && r.st != abe_pkg::ST_WAIT)
        |=> (r.st != abe_pkg::ST_IDLE && r.base == $past(r.base))
    ) else $error("start while busy disturbed the operation");
endmodule

// ===== pkg/abe_pkg.sv
// Constants and carrier types for the AES-128 block encrypt unit with record DMA
package abe_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] OFS_START   = 12'h000;
    localparam logic [11:0] OFS_STOP    = 12'h004;
    localparam logic [11:0] OFS_DONE    = 12'h100;
    localparam logic [11:0] OFS_ABORT   = 12'h104;
    localparam logic [11:0] OFS_IEN_SET = 12'h304;
    localparam logic [11:0] OFS_IEN_CLR = 12'h308;
    localparam logic [11:0] OFS_PTR     = 12'h504;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          BIT_TRIG    = 0;
    localparam int          BIT_FLAG    = 0;
    localparam int          BIT_IE_DONE = 0;
    localparam int          BIT_IE_ABRT = 1;
    localparam logic [1:0]  IEN_RESET   = 2'h0;

    // ****************************************************************
    // Record layout in data RAM
    // ****************************************************************
    localparam logic [31:0] REC_OUT_OFS = 32'h0000_0020;
    localparam logic [32:0] REC_BYTES   = 33'h0_0000_0030;
    localparam logic [32:0] WORD_BYTES  = 33'h0_0000_0004;
    localparam logic [3:0]  KEY_WORDS   = 4'h4;
    localparam logic [3:0]  FETCH_LAST  = 4'h7;
    localparam logic [3:0]  STORE_LAST  = 4'h3;
    localparam logic [3:0]  ROUND_FIRST = 4'h1;
    localparam logic [3:0]  ROUND_LAST  = 4'hA;
    localparam logic [31:0] RAM_BASE_DEF = 32'h2000_0000;
    localparam logic [31:0] RAM_SIZE_DEF = 32'h0001_0000;

    // ****************************************************************
    // Cipher constants
    // ****************************************************************
    localparam logic [7:0]  SBOX_AFFINE = 8'h63;
    localparam logic [7:0]  GF_POLY     = 8'h1B;
    localparam logic [7:0]  RCON_FIRST  = 8'h01;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int RUN_TIME_US    = 6;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int RUN_CYCLES_DEF = (RUN_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int RUN_CYCLES_MIN = 24;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_ROUND, ST_STORE, ST_WAIT} abe_state_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } abe_bus_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } abe_dma_s;
endpackage

// ===== testbench/abe_mem_model.sv
// Data RAM model answering the block's DMA master
`timescale 1ns/1ps
module abe_mem_model (
    input  wire logic              ref_clk_in, // System clock
    input  wire abe_pkg::abe_dma_s dma_in,     // DMA request from the block
    input  wire logic              slow_in,    // Answer every second cycle
    output logic                   ack_out,    // Request taken
    output logic [31:0]            rdata_out,  // Read data with ack
    output int                     count_out   // Accesses taken so far
);
    logic [31:0] mem [0:63];
    logic [31:0] last_q = 32'h0;
    logic        wait_q = 1'b0;
    int          count_q = 0;

    assign count_out = count_q;

    assign ack_out   = dma_in.req & (~slow_in | wait_q);
    // Stale data is inverted so a late sample cannot pass
    assign rdata_out = ack_out ? mem[dma_in.addr[7:2]] : ~last_q;

    always @(posedge ref_clk_in) begin
        wait_q <= dma_in.req & ~ack_out;
        if (ack_out) begin
            count_q   <= count_q + 1;
            last_q    <= dma_in.we ? dma_in.wdata : mem[dma_in.addr[7:2]];
            if (dma_in.we) begin
                mem[dma_in.addr[7:2]] <= dma_in.wdata;
            end
        end
    end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the AES-128 block encrypt unit
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } abe_row_s;

    localparam int          RUN = 40;
    localparam logic [31:0] PTR = 32'h2000_0040;
    localparam logic [31:0] VEC [12] = '{
        32'h0302_0100, 32'h0706_0504, 32'h0B0A_0908, 32'h0F0E_0D0C,
        32'h3322_1100, 32'h7766_5544, 32'hBBAA_9988, 32'hFFEE_DDCC,
        32'hD8E0_C469, 32'h3004_7B6A, 32'h80B7_CDD8, 32'h5AC5_B470};
    localparam abe_row_s ROWS [15] = '{
        '{1'b0, 12'h304, 32'h0, 32'h0}, '{1'b0, 12'h308, 32'h0, 32'h0},
        '{1'b0, 12'h100, 32'h0, 32'h0}, '{1'b0, 12'h104, 32'h0, 32'h0},
        '{1'b0, 12'h504, 32'h0, 32'h0}, '{1'b1, 12'h504, PTR, 32'h0},
        '{1'b0, 12'h504, 32'h0, PTR}, '{1'b1, 12'h304, 32'h3, 32'h0},
        '{1'b1, 12'h308, 32'h1, 32'h0}, '{1'b1, 12'h304, 32'h0, 32'h0},
        '{1'b0, 12'h304, 32'h0, 32'h2}, '{1'b1, 12'h304, 32'h1, 32'h0},
        '{1'b0, 12'h308, 32'h0, 32'h3}, '{1'b1, 12'h200, 32'hFFFF_FFFF, 32'h0},
        '{1'b0, 12'h200, 32'h0, 32'h0}};

    logic              ref_clk_in;
    logic              nrst_in;
    abe_pkg::abe_bus_s bus;
    logic [31:0]       rdata_out;
    logic              irq_out;
    abe_pkg::abe_dma_s dma;
    logic              dma_ack;
    logic [31:0]       dma_rdata;
    logic              claim;
    logic              core_req;
    logic              slow;
    int                acc;
    int                fails;
    int                tests_run;
    int                n;
    int                c0;

    abe_core #(.RUN_CYCLES(RUN), .RAM_BASE(32'h2000_0000), .RAM_SIZE(32'h0000_0100)) i_abe_core (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata_out),
        .irq_out(irq_out), .dma_out(dma), .dma_ack_in(dma_ack), .dma_rdata_in(dma_rdata),
        .core_claim_in(claim), .core_req_out(core_req));

    abe_mem_model i_abe_mem_model (.ref_clk_in(ref_clk_in), .dma_in(dma), .slow_in(slow),
        .ack_out(dma_ack), .rdata_out(dma_rdata), .count_out(acc));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_in) bus <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_in) bus <= '0;
        #1;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        @(posedge ref_clk_in) bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge ref_clk_in) bus <= '0;
        #1;
        chk($sformatf("register %h", a), e, rdata_out);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        #100000;
        fails++;
        final_report();
    end

    initial begin
        nrst_in   = 1'b0;
        bus       = '0;
        claim     = 1'b0;
        slow      = 1'b0;
        fails     = 0;
        tests_run = 0;
        repeat (5) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            if (ROWS[i].w) begin
                wr(ROWS[i].a, ROWS[i].d);
            end else begin
                rchk(ROWS[i].a, ROWS[i].e);
            end
        end
        $display("test register rows done");
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            for (int i = 0; i < 12; i++) begin
                i_abe_mem_model.mem[16 + i] = (i < 8) ? VEC[i] : 32'h0;
            end
            c0 = acc;
            wr(12'h000, 32'h1);
            tick(3);
            wr(12'h000, 32'h1);
            chk("core busy", 32'h1, {31'h0, core_req});
            chk("dma busy", 32'h1, {31'h0, dma.req});
            n = 5;
            while (irq_out !== 1'b1 && n < 400) begin
                tick(1);
                n++;
            end
            chk("done irq", 32'h1, {31'h0, irq_out});
            if (s == 0) begin
                chk("run time", 32'h1, {31'h0, n >= RUN - 3 && n <= RUN + 5});
            end
            for (int i = 0; i < 4; i++) begin
                chk("cipher word", VEC[8 + i], i_abe_mem_model.mem[24 + i]);
            end
            rchk(12'h100, 32'h1);
            rchk(12'h104, 32'h0);
            wr(12'h308, 32'h1);
            tick(2);
            chk("masked irq", 32'h0, {31'h0, irq_out});
            wr(12'h304, 32'h1);
            tick(2);
            chk("unmasked irq", 32'h1, {31'h0, irq_out});
            wr(12'h100, 32'h0);
            tick(2);
            chk("cleared irq", 32'h0, {31'h0, irq_out});
            chk("accesses", 32'hC, 32'(acc - c0));
            $display("test encrypt pass %0d done", s);
        end
        slow <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            wr(12'h000, 32'h1);
            tick(4);
            if (k == 0) begin
                wr(12'h004, 32'h1);
            end else begin
                @(posedge ref_clk_in) claim <= 1'b1;
                @(posedge ref_clk_in) claim <= 1'b0;
            end
            tick(3);
            c0 = acc;
            chk("dma request", 32'h0, {31'h0, dma.req});
            chk("core held", 32'h0, {31'h0, core_req});
            chk("abort irq", 32'h1, {31'h0, irq_out});
            rchk(12'h104, 32'h1);
            rchk(12'h100, 32'h0);
            tick(40);
            chk("late accesses", 32'h0, 32'(acc - c0));
            wr(12'h104, 32'h0);
            $display("test abort kind %0d done", k);
        end
        wr(12'h504, 32'h2000_00D4);
        c0 = acc;
        wr(12'h000, 32'h1);
        tick(3);
        rchk(12'h104, 32'h1);
        chk("stray accesses", 32'h0, 32'(acc - c0));
        wr(12'h104, 32'h0);
        wr(12'h504, PTR);
        $display("test bad pointer done");
        wr(12'h000, 32'h1);
        tick(4);
        @(posedge ref_clk_in) nrst_in <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        tick(1);
        chk("reset dma", 32'h0, {31'h0, dma.req});
        chk("reset core", 32'h0, {31'h0, core_req});
        chk("reset irq", 32'h0, {31'h0, irq_out});
        rchk(12'h304, 32'h0);
        rchk(12'h504, 32'h0);
        $display("test reset done");
        final_report();
    end
endmodule
